// >>> testbench/plp_core_assertions.sv
`timescale 1ns/1ps
////////////////////////////////////////////////////////////////////////////////
// Watches the core's ports for level selection and station transfer timing.
module plp_core_checker (
  input wire logic                         clk,
  input wire logic                         rst,
  input wire logic                         insn_boundary,
  input wire logic                         lvl_set_valid,
  input wire logic [plp_pkg::LVL_W-1:0]    lvl_set_level,
  input wire logic                         act_we,
  input wire logic                         mask_we,
  input wire logic [plp_pkg::LEVELS-1:0]   mask_wdata,
  input wire logic [2*plp_pkg::LEVELS-1:0] lvl_state,
  input wire logic [plp_pkg::LVL_W-1:0]    run_level,
  input wire logic                         run_valid,
  input wire logic                         fetch_valid,
  input wire logic                         cpu_hold,
  input wire logic                         mem_req,
  input wire logic [plp_pkg::MADDR_W-1:0]  mem_addr,
  input wire logic                         mem_ack,
  input wire logic [plp_pkg::ST_W-1:0]     st_sel,
  input wire logic                         st_enable,
  input wire logic                         st_indicator,
  input wire logic                         st_stop,
  input wire logic                         st_data_oe
);
  default clocking cb @(posedge clk); endclocking
  default disable iff (rst);

  // Level state follows its writers one cycle later.
  set_marks_act_a: assert property (lvl_set_valid && !act_we |=>
    lvl_state[plp_pkg::LEVELS + $past(lvl_set_level)]) else $error("level set lost");
  mask_load_a: assert property (mask_we |=>
    lvl_state[plp_pkg::LEVELS-1:0] == $past(mask_wdata)) else $error("mask not loaded");
  // Level entries happen only at an instruction boundary with the program free.
  fetch_at_boundary_a: assert property (fetch_valid |-> run_valid &&
    $past(insn_boundary) && !$past(cpu_hold)) else $error("entry off boundary");
  switch_boundary_a: assert property (run_valid && $changed(run_level) |->
    $past(insn_boundary)) else $error("level switched off boundary");
  // A grant opens with the key word of the granted station.
  key_addr_a: assert property ($rose(st_enable) |-> mem_req && !mem_addr[0] &&
    mem_addr[6:4] == st_sel) else $error("grant without key fetch");
  mem_hold_a: assert property (mem_req && !mem_ack |=>
    mem_req && $stable(mem_addr)) else $error("memory request dropped");
  io_holds_cpu_a: assert property (mem_req |-> cpu_hold)
    else $error("program ran during transfer");
  drive_dir_a: assert property (st_data_oe |-> st_enable && st_indicator)
    else $error("data driven outside output");
  stop_pulse_a: assert property (st_stop |=> !st_stop)
    else $error("stop longer than a cycle");

  // Main scenarios.
  grant_c: cover property ($rose(st_enable));
  entry_c: cover property (fetch_valid);
  stop_c: cover property (st_stop);
endmodule

bind plp_core plp_core_checker plp_core_checker_i (
  .clk, .rst, .insn_boundary, .lvl_set_valid, .lvl_set_level, .act_we, .mask_we,
  .mask_wdata, .lvl_state, .run_level, .run_valid, .fetch_valid, .cpu_hold, .mem_req,
  .mem_addr, .mem_ack, .st_sel, .st_enable, .st_indicator, .st_stop, .st_data_oe
);

// >>> testbench/plp_unit_model.sv
`timescale 1ns/1ps
////////////////////////////////////////////////////////////////////////////////
// Interface unit at one station: own request line, its substation, input data.
module plp_unit_model #(
  parameter logic [2:0] STATION = 3'h2
) (
  input  wire logic        clk,
  input  wire logic        rst,
  input  wire logic        go,
  input  wire logic        burst,
  input  wire logic        err_in,
  input  wire logic [2:0]  st_sel,
  input  wire logic        st_enable,
  input  wire logic        st_indicator,
  input  wire logic [31:0] st_data_o,
  input  wire logic        st_data_oe,
  output logic             req,
  output logic [2:0]       st_sub,
  output logic             st_error,
  output logic [31:0]      st_data_i,
  output logic [31:0]      cap
);
  logic        mine;
  logic [3:0]  len_q;
  logic [31:0] last_q;

  // The unit names its own substation and reports faults only while served.
  assign mine = st_enable && st_sel == STATION;
  assign st_sub = 3'h1;
  assign st_error = err_in && mine;

  // A burst request is held for two words; a single one drops once accepted.
  always @(posedge clk or posedge rst) begin
    if (rst) begin
      req <= 1'b0;
      len_q <= 4'h0;
    end else begin
      len_q <= mine ? len_q + 4'h1 : 4'h0;
      if (go) req <= 1'b1;
      else if (mine && (!burst || len_q == 4'h6)) req <= 1'b0;
    end
  end

  // Captures output words; the input word stands while the unit requests, since the
  // controller takes it through its synchroniser before the grant is visible here.
  // A released bus shows the inverse of its last value.
  always @(posedge clk or posedge rst) begin
    if (rst) begin
      last_q <= 32'h0;
      cap <= 32'h0;
    end else begin
      if (st_data_oe && mine) cap <= st_data_o;
      last_q <= st_data_i;
    end
  end
  assign st_data_i = req ? 32'hC0DE_0042 : ~last_q;
endmodule

// >>> testbench/tb.sv
`timescale 1ns/1ps
////////////////////////////////////////////////////////////////////////////////
// Drives the core as instruction control and memory would, and checks its answers.
module tb;
  logic         clk = 0, rst = 1, insn_boundary = 0, lvl_set_valid = 0, act_we = 0;
  logic         mask_we = 0, preg_we = 0, sp_we = 0, mem_rvalid = 0, mem_ack = 0;
  logic         go = 0, burst = 0, err_in = 0, req5 = 0, mreq;
  logic         run_valid, fetch_valid, cpu_hold, mem_req, mem_we, st_error;
  logic         st_enable, st_indicator, st_stop, st_data_oe;
  logic [2:0]   acc_sel = 0, st_sub, st_sel;
  logic [3:0]   sp_ext = 0;
  logic [5:0]   lvl_set_level = 0, sp_level = 0, run_level;
  logic [7:0]   st_req;
  logic [12:0]  sp_start = 0;
  logic [15:0]  preg_wdata = 0, preg_rdata;
  logic [16:0]  fetch_addr, mem_addr, faddr;
  logic [31:0]  mem_rdata = 0, mem_wdata, st_data_i, st_data_o, cap;
  logic [63:0]  act_wdata = 0, mask_wdata = 0;
  logic [127:0] lvl_state;
  logic [31:0]  m [int];
  logic [2:0]   sels [$];
  int           err_count = 0, total_checks = 0, cyc = 0, fcount = 0, en_rises = 0;
  int           ph = 0, r = 0;

  assign st_req = {2'b00, req5, 2'b00, mreq, 2'b00};

  plp_core plp_core_i (
    .clk, .rst, .insn_boundary, .lvl_set_valid, .lvl_set_level, .act_we, .act_wdata,
    .mask_we, .mask_wdata, .acc_sel, .preg_we, .preg_wdata, .preg_rdata, .sp_we,
    .sp_level, .sp_start, .sp_ext, .lvl_state, .run_level, .run_valid, .fetch_valid,
    .fetch_addr, .cpu_hold, .mem_req, .mem_we, .mem_addr, .mem_wdata, .mem_rvalid,
    .mem_rdata, .mem_ack, .st_req, .st_sub, .st_error, .st_sel, .st_enable,
    .st_indicator, .st_stop, .st_data_i, .st_data_o, .st_data_oe
  );

  plp_unit_model plp_unit_model_i (
    .clk, .rst, .go, .burst, .err_in, .st_sel, .st_enable, .st_indicator, .st_data_o,
    .st_data_oe, .req(mreq), .st_sub, .st_error, .st_data_i, .cap
  );

  // Clock of 100 ns period.
  always #50 clk = ~clk;

  // Memory gives read data, then an acknowledge, then rests one cycle.
  always @(posedge clk) begin
    #1;
    mem_ack = (ph == 1);
    mem_rvalid = (ph == 0) && mem_req;
    if (mem_ack && mem_we) m[mem_addr] = mem_wdata;
    if (mem_rvalid) mem_rdata = m.exists(mem_addr) ? m[mem_addr] : 32'h0;
    ph = mem_rvalid ? 1 : ((ph == 1) ? 2 : 0);
  end

  // Records entries and grants, bounds the run.
  always @(negedge clk) begin
    cyc++;
    if (fetch_valid) begin
      fcount++;
      faddr = fetch_addr;
    end
    if ($rose(st_enable)) begin
      en_rises++;
      sels.push_back(st_sel);
    end
    if (cyc > 20000) begin
      err_count++;
      summarize();
    end
  end

  task automatic tick(input int n = 1);
    repeat (n) @(posedge clk);
    #1;
  endtask

  task automatic chk(input string n, input logic [63:0] e, input logic [63:0] s);
    total_checks++;
    if (s !== e) begin
      err_count++;
      $display("BAD %s expected %h seen %h", n, e, s);
    end
  endtask

  task automatic summarize;
    $display("checks %0d errors %0d", total_checks, err_count);
    if (err_count == 0 && total_checks > 0) $display("[ PASS ]");
    else $display("[ FAIL ]");
    $finish;
  endtask

  // Writes the activity (a=1) or mask (a=0) register, then lets the level settle.
  task automatic wr_state(input logic a, input logic [63:0] v);
    act_we = a;
    mask_we = !a;
    act_wdata = v;
    mask_wdata = v;
    tick();
    act_we = 0;
    mask_we = 0;
    tick(3);
  endtask

  task automatic pulse_lvl(input logic [5:0] l);
    lvl_set_level = l;
    lvl_set_valid = 1;
    tick();
    lvl_set_valid = 0;
    tick(3);
  endtask

  task automatic wr_preg(input logic [15:0] base);
    for (int k = 0; k < 8; k++) begin
      acc_sel = k[2:0];
      preg_wdata = base + 16'(k);
      preg_we = 1;
      tick();
    end
    preg_we = 0;
  endtask

  task automatic rd_preg(input logic [15:0] base);
    for (int k = 0; k < 8; k++) begin
      acc_sel = k[2:0];
      tick(2);
      chk("process reg", base + 16'(k), preg_rdata);
    end
  endtask

  // Raises a request at the unit, and at station five in step with it when two
  // runs are wanted, then waits for that many stop pulses; station five drops
  // its request once served.
  task automatic serve(input int stops = 1);
    int n;
    go = 1;
    tick();
    go = 0;
    if (stops > 1) req5 = 1;
    n = 0;
    while (stops > 0 && n < 400) begin
      tick();
      n++;
      if (st_stop) stops--;
      if (st_enable && st_sel == 3'h5) req5 = 0;
    end
    chk("stops left", 0, stops);
    tick(2);
  endtask

  initial begin
    tick(8);
    rst = 0;
    insn_boundary = 1;
    tick(3);
    chk("activity", plp_pkg::ACT_RESET, lvl_state[127:64]);
    chk("mask", plp_pkg::MASK_RESET, lvl_state[63:0]);
    chk("run valid", 0, run_valid);
    for (int l = 3; l <= 5; l += 2) begin
      sp_level = l[5:0];
      sp_start = 13'h0100 + 13'(l);
      sp_ext = 4'h3;
      sp_we = 1;
      tick();
    end
    sp_we = 0;
    wr_state(0, '1);
    pulse_lvl(5);
    chk("run level", 5, run_level);
    chk("entry addr", 17'h06105, faddr);
    wr_preg(16'h5000);
    wr_state(1, 64'h28);
    chk("run level", 3, run_level);
    chk("entry addr", 17'h06103, faddr);
    wr_preg(16'h3000);
    wr_state(0, ~64'h8);
    chk("run level", 5, run_level);
    rd_preg(16'h5000);
    wr_state(0, '1);
    rd_preg(16'h3000);
    chk("entries", 4, fcount);
    insn_boundary = 0;
    pulse_lvl(1);
    chk("run level", 3, run_level);
    insn_boundary = 1;
    tick(3);
    chk("run level", 1, run_level);
    wr_state(1, 64'h0);
    chk("run valid", 0, run_valid);
    // Two stations at once: both output one word each.
    m[17'h01000] = 32'h1234_5678;
    m[17'h01100] = 32'h9ABC_DEF0;
    m[17'h00422] = {17'h01000, 12'h001, 3'b100};
    m[17'h00423] = {6'd10, 6'd11, 4'h0, 16'h0};
    m[17'h00452] = {17'h01100, 12'h001, 3'b100};
    m[17'h00453] = {6'd12, 6'd13, 4'h0, 16'h0};
    serve(2);
    chk("first grant", 2, sels[0]);
    chk("second grant", 5, sels[1]);
    chk("output word", 32'h1234_5678, cap);
    chk("key update", {17'h01001, 12'h000, 3'b100}, m[17'h00422]);
    chk("normal reason", 1, m[17'h00423][16]);
    chk("levels raised", 2'b11, {lvl_state[74], lvl_state[76]});
    chk("program resumed", 0, cpu_hold);
    // Burst input of two words.
    m[17'h00422] = {17'h02000, 12'h002, 3'b010};
    burst = 1;
    r = en_rises;
    serve();
    chk("burst grants", r + 1, en_rises);
    chk("input word", 32'hC0DE_0042, m[17'h02000]);
    chk("input word", 32'hC0DE_0042, m[17'h02001]);
    chk("key update", {17'h02002, 12'h000, 3'b010}, m[17'h00422]);
    // Fault at the unit ends the run early.
    m[17'h00422] = {17'h03000, 12'h003, 3'b100};
    burst = 0;
    err_in = 1;
    serve();
    chk("abnormal reason", 1, m[17'h00423][17]);
    chk("abnormal level", 1, lvl_state[75]);
    summarize();
  end
endmodule

// >>> verilog/plp_core.sv
`timescale 1ns/1ps
// Contract
// [RULE1] Scan device requests, grant highest priority.
// [RULE2] Each transfer steals exactly two memory cycles; the code adds a third, terminate, cycle after the last transfer.
// [RULE3] Program resumes only with no pending request.
// [RULE4] Burst mode services back to back.
// [RULE5] Controller decodes one of eight stations.
// [RULE6] Interface unit decodes its eight substations.
// [RULE7] One shared two-way data subchannel.
// [RULE8] Common control: select, enable, indicator, stop.
// [RULE9] Each station has its own request line.
// [RULE10] Transfers steered by key and terminate words.
// [RULE11] Words hold address, count, mode, levels.
// [RULE12] Only the highest active level executes.
// [RULE13] Levels activated by instruction or I/O.
// [RULE14] 64-bit activity and mask registers.
// [RULE15] Running level: activity and mask both set.
// [RULE16] Eight process registers per level, no saving.
// [RULE17] Level entry fetches from its start pointer.
// [RULE18] Extension register selects the memory module.
// [RULE19] Accumulator field picks running level register.
// [RULE20] Activity and enable bits mirrored as 128 bits.
// [RULE21] Level register steers register set and pointer.
// [RULE22] Switch at instruction boundary; idle if none.
// [RULE23] Key updated per transfer; terminate at zero.

////////////////////////////////////////////////////////////////////////////////

module plp_fifo #(
  parameter int unsigned W = 32,
  parameter int unsigned D = 4
) (
  input  wire logic         clk,
  input  wire logic         rst,
  input  wire logic         in_valid,
  output logic              in_ready,
  input  wire logic [W-1:0] in_data,
  output logic              out_valid,
  input  wire logic         out_ready,
  output logic [W-1:0]      out_data
);
  localparam int unsigned AW = (D > 1) ? $clog2(D) : 1;
  logic [W-1:0]  mem_q [0:D-1];
  logic [AW-1:0] wp_q;
  logic [AW-1:0] rp_q;
  logic [AW:0]   cnt_q;
  logic          push;
  logic          pop;

  // Full and empty come straight from the fill count.
  assign in_ready  = (cnt_q != (AW+1)'(D));
  assign out_valid = (cnt_q != '0);
  assign out_data  = mem_q[rp_q];
  assign push      = in_valid && in_ready;
  assign pop       = out_valid && out_ready;

  // Storage write.
  always_ff @(posedge clk) begin
    if (push) begin
      mem_q[wp_q] <= in_data;
    end
  end

  // Pointers wrap at the depth; the count runs from zero to the depth.
  always_ff @(posedge clk or posedge rst) begin
    if (rst) begin
      wp_q  <= '0;
      rp_q  <= '0;
      cnt_q <= '0;
    end else begin
      if (push) begin
        wp_q <= (wp_q == AW'(D-1)) ? '0 : wp_q + 1'b1;
      end
      if (pop) begin
        rp_q <= (rp_q == AW'(D-1)) ? '0 : rp_q + 1'b1;
      end
      cnt_q <= cnt_q + (AW+1)'(push) - (AW+1)'(pop);
    end
  end
endmodule

////////////////////////////////////////////////////////////////////////////////

module plp_core (
  input  wire logic                             clk,
  input  wire logic                             rst,
  // Instruction control side.
  input  wire logic                             insn_boundary,
  input  wire logic                             lvl_set_valid,
  input  wire logic [plp_pkg::LVL_W-1:0]        lvl_set_level,
  input  wire logic                             act_we,
  input  wire logic [plp_pkg::LEVELS-1:0]       act_wdata,
  input  wire logic                             mask_we,
  input  wire logic [plp_pkg::LEVELS-1:0]       mask_wdata,
  input  wire logic [2:0]                       acc_sel,
  input  wire logic                             preg_we,
  input  wire logic [plp_pkg::PREG_W-1:0]       preg_wdata,
  output logic      [plp_pkg::PREG_W-1:0]       preg_rdata,
  input  wire logic                             sp_we,
  input  wire logic [plp_pkg::LVL_W-1:0]        sp_level,
  input  wire logic [plp_pkg::START_W-1:0]      sp_start,
  input  wire logic [plp_pkg::EXT_W-1:0]        sp_ext,
  output logic      [2*plp_pkg::LEVELS-1:0]     lvl_state,
  output logic      [plp_pkg::LVL_W-1:0]        run_level,
  output logic                                  run_valid,
  output logic                                  fetch_valid,
  output logic      [plp_pkg::MADDR_W-1:0]      fetch_addr,
  output logic                                  cpu_hold,
  // Memory cycle port.
  output logic                                  mem_req,
  output logic                                  mem_we,
  output logic      [plp_pkg::MADDR_W-1:0]      mem_addr,
  output logic      [plp_pkg::WORD_W-1:0]       mem_wdata,
  input  wire logic                             mem_rvalid,
  input  wire logic [plp_pkg::WORD_W-1:0]       mem_rdata,
  input  wire logic                             mem_ack,
  // Station bus.
  input  wire logic [plp_pkg::STATIONS-1:0]     st_req,
  input  wire logic [plp_pkg::ST_W-1:0]         st_sub,
  input  wire logic                             st_error,
  output logic      [plp_pkg::ST_W-1:0]         st_sel,
  output logic                                  st_enable,
  output logic                                  st_indicator,
  output logic                                  st_stop,
  input  wire logic [plp_pkg::WORD_W-1:0]       st_data_i,
  output logic      [plp_pkg::WORD_W-1:0]       st_data_o,
  output logic                                  st_data_oe
);
  localparam int unsigned SYN_W = plp_pkg::STATIONS + plp_pkg::ST_W + 1 + plp_pkg::WORD_W;

  // Lowest index wins; the valid flag rides in the top bit.
  function automatic logic [6:0] prio64(input logic [63:0] v);
    prio64 = '0;
    for (int i = 63; i >= 0; i--) begin
      if (v[i]) begin
        prio64 = {1'b1, 6'(i)};
      end
    end
  endfunction

  logic [plp_pkg::LEVELS-1:0]  act_q;
  logic [plp_pkg::LEVELS-1:0]  mask_q;
  logic [plp_pkg::PREG_W-1:0]  preg_q [0:plp_pkg::LEVELS*plp_pkg::PREGS-1];
  logic [plp_pkg::START_W-1:0] start_q [0:plp_pkg::LEVELS-1];
  logic [plp_pkg::EXT_W-1:0]   ext_q [0:plp_pkg::LEVELS-1];
  logic [6:0]                  best;
  logic [8:0]                  preg_idx;
  logic [SYN_W-1:0]            syn1_q;
  logic [SYN_W-1:0]            syn2_q;
  logic [plp_pkg::STATIONS-1:0] req_s;
  logic [plp_pkg::ST_W-1:0]    sub_s;
  logic                        err_s;
  logic [plp_pkg::WORD_W-1:0]  din_s;
  plp_pkg::plp_io_e            io_q;
  plp_pkg::plp_key_s           key_q;
  plp_pkg::plp_term_s          term_q;
  logic [plp_pkg::ST_W-1:0]    sub_q;
  logic                        abn_q;
  logic                        rd_done_q;
  logic                        pend;
  logic [6:0]                  st_best;
  logic                        grant;
  logic                        act_io_set;
  logic [plp_pkg::LVL_W-1:0]   act_io_lvl;
  logic                        f_in_ready;
  logic                        f_out_valid;
  logic                        f_push;
  logic                        f_pop;
  logic [plp_pkg::WORD_W-1:0]  f_out_data;
  logic                        last_xfer;

  ////////////////////////////////////////////////////////////////////////////////

  // Station pins pass two flip-flops before use.
  always_ff @(posedge clk or posedge rst) begin
    if (rst) begin
      syn1_q <= '0;
      syn2_q <= '0;
    end else begin
      syn1_q <= {st_req, st_sub, st_error, st_data_i};
      syn2_q <= syn1_q;
    end
  end
  assign {req_s, sub_s, err_s, din_s} = syn2_q;

  // Level selection and process register addressing.
  assign best     = prio64(act_q & mask_q); // [RULE12] [RULE15]
  assign preg_idx = {run_level, acc_sel}; // [RULE16] [RULE19] [RULE21]
  assign lvl_state = {act_q, mask_q}; // [RULE20]

  // Activity and mask; hardware sets win over software writes.
  always_ff @(posedge clk or posedge rst) begin
    if (rst) begin
      act_q  <= plp_pkg::ACT_RESET;
      mask_q <= plp_pkg::MASK_RESET;
    end else begin
      if (mask_we) begin
        mask_q <= mask_wdata; // [RULE14]
      end
      act_q <= (act_we ? act_wdata : act_q) // [RULE14]
               | (lvl_set_valid ? (64'h1 << lvl_set_level) : '0) // [RULE13]
               | (act_io_set ? (64'h1 << act_io_lvl) : '0); // [RULE13]
    end
  end

  // Running level moves only at an instruction boundary, never during a steal.
  always_ff @(posedge clk or posedge rst) begin
    if (rst) begin
      run_level   <= '0;
      run_valid   <= 1'b0;
      fetch_valid <= 1'b0;
      fetch_addr  <= '0;
    end else begin
      fetch_valid <= 1'b0;
      if (insn_boundary && !cpu_hold) begin
        run_valid <= best[6]; // [RULE22]
        run_level <= best[5:0];
        if (best[6] && (!run_valid || best[5:0] != run_level)) begin
          fetch_valid <= 1'b1;
          fetch_addr  <= {ext_q[best[5:0]], start_q[best[5:0]]}; // [RULE17] [RULE18]
        end
      end
    end
  end

  // Per-level register sets; only the running level's set is touched.
  always_ff @(posedge clk) begin
    if (preg_we && run_valid) begin
      preg_q[preg_idx] <= preg_wdata; // [RULE16]
    end
    if (sp_we) begin
      start_q[sp_level] <= sp_start;
      ext_q[sp_level]   <= sp_ext;
    end
  end

  // Accumulator read data is registered.
  always_ff @(posedge clk or posedge rst) begin
    if (rst) begin
      preg_rdata <= '0;
    end else begin
      preg_rdata <= preg_q[preg_idx]; // [RULE19]
    end
  end

  ////////////////////////////////////////////////////////////////////////////////

  // Request scan: lowest station number is highest priority.
  assign st_best   = prio64({56'h0, req_s}); // [RULE9]
  assign pend      = st_best[6];
  assign grant     = pend && f_in_ready; // [RULE1]
  assign last_xfer = (key_q.count == '0) || err_s;
  assign cpu_hold  = (io_q != plp_pkg::IO_IDLE) || pend; // [RULE3]

  // Memory cycle requests by sequencer state.
  always_comb begin
    mem_req   = 1'b0;
    mem_we    = 1'b0;
    mem_addr  = plp_pkg::CW_BASE + {10'h0, st_sel, sub_q, 1'b0}; // [RULE10]
    mem_wdata = '0;
    case (io_q)
      plp_pkg::IO_KEY: begin
        mem_req   = 1'b1;
        mem_we    = 1'b1;
        mem_wdata = key_q; // [RULE23]
      end
      plp_pkg::IO_DATA: begin
        mem_req   = key_q.mode[plp_pkg::MODE_OUT] || f_out_valid;
        mem_we    = !key_q.mode[plp_pkg::MODE_OUT];
        mem_addr  = key_q.addr - 1'b1;
        mem_wdata = f_out_data;
      end
      plp_pkg::IO_TERM: begin
        mem_req   = 1'b1;
        mem_we    = 1'b1;
        mem_addr  = plp_pkg::CW_BASE + {10'h0, st_sel, sub_q, 1'b1};
        mem_wdata = term_q;
      end
      default: begin
        mem_req = 1'b0;
      end
    endcase
  end

  // Input words are parked in the FIFO until their memory cycle.
  assign f_push = (io_q == plp_pkg::IO_KEY) && mem_rvalid && !mem_rdata[plp_pkg::MODE_OUT];
  assign f_pop  = (io_q == plp_pkg::IO_DATA) && mem_ack && !key_q.mode[plp_pkg::MODE_OUT];

  // Transfer sequencer: key cycle, data cycle, optional terminate cycle.
  always_ff @(posedge clk or posedge rst) begin
    if (rst) begin
      io_q         <= plp_pkg::IO_IDLE;
      key_q        <= '0;
      term_q       <= '0;
      sub_q        <= '0;
      abn_q        <= 1'b0;
      rd_done_q    <= 1'b0;
      st_sel       <= '0;
      st_enable    <= 1'b0;
      st_indicator <= 1'b0;
      st_stop      <= 1'b0;
      st_data_o    <= '0;
      st_data_oe   <= 1'b0;
      act_io_set   <= 1'b0;
      act_io_lvl   <= '0;
    end else begin
      st_stop    <= 1'b0;
      act_io_set <= 1'b0;
      if (mem_ack) begin
        rd_done_q <= 1'b0;
      end else if (mem_rvalid) begin
        rd_done_q <= 1'b1;
      end
      case (io_q)
        plp_pkg::IO_IDLE: begin
          if (grant) begin
            st_sel    <= st_best[2:0]; // [RULE5]
            sub_q     <= sub_s; // [RULE6]
            st_enable <= 1'b1; // [RULE8]
            io_q      <= plp_pkg::IO_KEY; // [RULE2]
          end
        end
        plp_pkg::IO_KEY: begin
          if (mem_rvalid && !rd_done_q) begin
            key_q.addr   <= mem_rdata[31:15] + 1'b1; // [RULE11] [RULE23]
            key_q.count  <= mem_rdata[14:3] - 1'b1; // [RULE23]
            key_q.mode   <= mem_rdata[2:0]; // [RULE11]
            st_indicator <= mem_rdata[plp_pkg::MODE_OUT]; // [RULE8]
          end
          if (mem_ack) begin
            io_q <= plp_pkg::IO_DATA; // [RULE2]
          end
        end
        plp_pkg::IO_DATA: begin
          if (mem_rvalid && key_q.mode[plp_pkg::MODE_OUT]) begin
            st_data_o  <= mem_rdata; // [RULE7]
            st_data_oe <= 1'b1; // [RULE7]
          end
          if (mem_ack) begin
            st_data_oe <= 1'b0;
            if (last_xfer) begin
              abn_q <= err_s;
              io_q  <= plp_pkg::IO_TERM; // [RULE23]
            end else if (key_q.mode[plp_pkg::MODE_BURST] && grant
                         && st_best[2:0] == st_sel) begin
              io_q <= plp_pkg::IO_KEY; // [RULE4]
            end else begin
              st_enable <= 1'b0;
              io_q      <= plp_pkg::IO_IDLE; // [RULE3]
            end
          end
        end
        plp_pkg::IO_TERM: begin
          if (mem_rvalid && !rd_done_q) begin
            term_q <= mem_rdata; // [RULE11]
            term_q.reason[plp_pkg::RSN_NORMAL] <= !abn_q;
            term_q.reason[plp_pkg::RSN_ABN]    <= abn_q;
          end
          if (mem_ack) begin
            act_io_set <= 1'b1; // [RULE13]
            act_io_lvl <= abn_q ? term_q.lvl_abn : term_q.lvl_norm; // [RULE11]
            st_stop    <= 1'b1; // [RULE8]
            st_enable  <= 1'b0;
            io_q       <= plp_pkg::IO_IDLE;
          end
        end
        default: begin
          io_q <= plp_pkg::IO_IDLE;
        end
      endcase
    end
  end

  // Input data buffer; a full FIFO holds off new grants.
  plp_fifo #(
    .W (plp_pkg::WORD_W),
    .D (plp_pkg::FIFO_DEPTH)
  ) u_fifo (
    .clk       (clk),
    .rst       (rst),
    .in_valid  (f_push),
    .in_ready  (f_in_ready),
    .in_data   (din_s),
    .out_valid (f_out_valid),
    .out_ready (f_pop),
    .out_data  (f_out_data)
  );
endmodule

// >>> verilog/plp_pkg.sv
package plp_pkg;

  // Program level sizes.
  localparam int unsigned LEVELS     = 64;
  localparam int unsigned LVL_W      = 6;
  localparam int unsigned PREGS      = 8;
  localparam int unsigned PREG_W     = 16;
  localparam int unsigned START_W    = 13;
  localparam int unsigned EXT_W      = 4;
  localparam int unsigned MADDR_W    = 17;

  // I/O sizes.
  localparam int unsigned STATIONS   = 8;
  localparam int unsigned ST_W       = 3;
  localparam int unsigned WORD_W     = 32;
  localparam int unsigned CNT_W      = 12;
  localparam int unsigned FIFO_DEPTH = 4;

  // Control word pair base; pair n sits at base + 2n.
  localparam logic [MADDR_W-1:0] CW_BASE = 17'h00400;

  // Reset values.
  localparam logic [LEVELS-1:0]  ACT_RESET  = 64'h0000_0000_0000_0000;
  localparam logic [LEVELS-1:0]  MASK_RESET = 64'h0000_0000_0000_0000;

  // Mode field bit positions inside the key word.
  localparam int unsigned MODE_CHAR  = 0;
  localparam int unsigned MODE_BURST = 1;
  localparam int unsigned MODE_OUT   = 2;

  // Key word: address, count, mode.
  typedef struct packed {
    logic [MADDR_W-1:0] addr;
    logic [CNT_W-1:0]   count;
    logic [2:0]         mode;
  } plp_key_s;

  // Terminate word: normal level, abnormal level, reason bits, spare.
  typedef struct packed {
    logic [LVL_W-1:0] lvl_norm;
    logic [LVL_W-1:0] lvl_abn;
    logic [3:0]       reason;
    logic [15:0]      spare;
  } plp_term_s;

  // Reason bit positions.
  localparam int unsigned RSN_NORMAL = 0;
  localparam int unsigned RSN_ABN    = 1;

  // I/O sequencer states.
  typedef enum logic [1:0] {
    IO_IDLE = 2'b00,
    IO_KEY  = 2'b01,
    IO_DATA = 2'b10,
    IO_TERM = 2'b11
  } plp_io_e;

endpackage
